// File: shared/nvmca_pkg.sv
// Overview of operation
// - forty one-time-programmable configuration bits held
// - stored configuration loaded as power-up default
// - channel thresholds, off-times, enables in bits 31:0
// - failsafe, recovery, overcurrent, lock in 39:32
// - data register shows 10-bit slice by address
// - data register valid after host refresh, zero at reset
// - operation codes 0 and 3 do nothing
// - code 1 refreshes all forty bits
// - code 2 programs mapped fields plus lock bit
// - programming allowed only while lock unprogrammed
// - lock bit programmed in the same pass
// - active status high while any operation runs
// - trim register read-only, odd parity, zero reset
// - revision register ten bits, bit 9 zero
// - undetermined reset bits set by trim or diagnostics
// - boost undervoltage during programming sets sticky fail
// - high and low bias bits alter host refresh reads
package nvmca_pkg;
  // ----------------------------------------
  // sizes and register offsets
  // ----------------------------------------
  localparam int NVM_BITS = 40;
  localparam int REG_W = 10;
  localparam logic [4:0] ADDR_TRIM = 5'h1d;
  localparam logic [4:0] ADDR_DATA = 5'h1e;
  localparam logic [4:0] ADDR_REV = 5'h1f;
  localparam logic [9:0] DATA_RESET = 10'h000;
  localparam logic [9:0] TRIM_RESET = 10'h000;
  // ----------------------------------------
  // store bit positions
  // ----------------------------------------
  localparam int POS_CH1_VTH = 0;
  localparam int POS_CH1_ISNS = 8;
  localparam int POS_CH2_VTH = 10;
  localparam int POS_CH2_ISNS = 18;
  localparam int POS_CH1_TOFF = 20;
  localparam int POS_CH2_TOFF = 25;
  localparam int POS_CH1_EN = 30;
  localparam int POS_CH2_EN = 31;
  localparam int POS_FSO = 32;
  localparam int POS_CH1_TAR = 35;
  localparam int POS_CH2_TAR = 36;
  localparam int POS_OCC = 37;
  localparam int POS_LOCK = 39;
  localparam int TRIM_PARITY_BIT = 8;
  // ----------------------------------------
  // revision field: fixed bits 9:5, mask and metal codes arbitrary
  // ----------------------------------------
  localparam logic [4:0] REV_FIXED_HI = 5'h08;
  localparam logic [1:0] REV_FULL_MASK = 2'h0;
  localparam logic [1:0] REV_METAL = 2'h0;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int REFRESH_TIME_NS = 500;
  localparam int PROG_TIME_NS = 100000;
  localparam int REFRESH_CYCLES = (REFRESH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PROG_CYCLES = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ----------------------------------------
  // operation codes and states
  // ----------------------------------------
  typedef enum logic [1:0] {
    NVMCA_OP_NOP = 2'h0,
    NVMCA_OP_REFRESH = 2'h1,
    NVMCA_OP_PROGRAM = 2'h2,
    NVMCA_OP_NOP3 = 2'h3
  } nvmca_op_e;
  typedef enum logic [1:0] {
    NVMCA_IDLE = 2'h0,
    NVMCA_REFRESH = 2'h1,
    NVMCA_PROGRAM = 2'h2
  } nvmca_state_e;
  // mapped configuration fields, 39 bits
  typedef struct packed {
    logic [1:0] overcurrent_comparator_level;
    logic ch2_thermal_auto_recover;
    logic ch1_thermal_auto_recover;
    logic [2:0] failsafe_mode_select;
    logic ch2_enable;
    logic ch1_enable;
    logic [4:0] ch2_off_time;
    logic [4:0] ch1_off_time;
    logic [1:0] ch2_current_sense_threshold;
    logic [7:0] ch2_voltage_threshold;
    logic [1:0] ch1_current_sense_threshold;
    logic [7:0] ch1_voltage_threshold;
  } nvmca_cfg_s;
endpackage

// File: hdl/nvmca_ctrl.sv
`timescale 1ns/10ps
module nvmca_ctrl
  import nvmca_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce,
  // register read port
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  output logic [9:0] reg_rdata,
  output logic reg_rvalid,
  // operation controls
  input wire logic op_wr,
  input wire logic [1:0] op_code,
  input wire logic [1:0] slice_addr,
  input wire logic bias_high,
  input wire logic bias_low,
  input wire nvmca_cfg_s cfg_fields,
  input wire logic status_rd,
  output logic otp_active,
  output logic prog_fail,
  output nvmca_cfg_s cfg_default,
  output logic cfg_default_valid,
  // factory trim and supply monitor
  input wire logic trim_load,
  input wire logic [3:0] spare_trim_nibble,
  input wire logic boost_uv,
  // fuse macro side
  output logic fuse_read,
  output logic fuse_prog,
  output logic fuse_bias_high,
  output logic fuse_bias_low,
  output logic [39:0] fuse_wdata,
  input wire logic [39:0] fuse_rdata
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // pick a 10-bit slice of the store image
  function automatic logic [9:0] slice_of(input logic [39:0] img, input logic [1:0] a);
    logic [9:0] s;
    s = '0;
    case (a)
      2'h0: s = img[9:0];
      2'h1: s = img[19:10];
      2'h2: s = img[29:20];
      default: s = img[39:30];
    endcase
    return s;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  nvmca_state_e state_q; // operation state
  logic [15:0] cnt_q; // remaining cycles of operation
  logic host_op_q; // refresh started by host, not power-up
  logic boot_q; // power-up refresh still pending
  logic lock_q; // lock bit seen in the store or set by a finished program
  logic [39:0] image_q; // store image from last refresh
  logic [9:0] data_q; // readback slice register
  logic [9:0] trim_q; // trim register
  logic fail_q; // sticky programming failure
  logic [9:0] rdata_q; // read data flop
  logic rvalid_q; // read valid flop
  // decoded strobes of this cycle
  logic start_ref; // accepted refresh request
  logic start_prog; // accepted program request
  logic finish; // last cycle of current operation

  // accepted only when idle; busy writes dropped
  assign start_ref = ce && state_q == NVMCA_IDLE && (boot_q || (op_wr && op_code == NVMCA_OP_REFRESH));
  // program blocked once lock has been seen
  assign start_prog = ce && state_q == NVMCA_IDLE && !boot_q && op_wr && op_code == NVMCA_OP_PROGRAM
    && !lock_q;
  // last countdown cycle, only on an enabled edge
  assign finish = ce && state_q != NVMCA_IDLE && cnt_q == 16'h0001;

  // ----------------------------------------
  // operation sequencer
  // ----------------------------------------
  // codes 0 and 3 fall through and leave the store alone
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= NVMCA_IDLE;
      cnt_q <= 16'h0000;
    end else if (ce) begin
      case (state_q)
        NVMCA_IDLE: begin
          if (start_ref) begin
            state_q <= NVMCA_REFRESH;
            cnt_q <= 16'(REFRESH_CYCLES);
          end else if (start_prog) begin
            state_q <= NVMCA_PROGRAM;
            cnt_q <= 16'(PROG_CYC);
          end
        end
        NVMCA_REFRESH, NVMCA_PROGRAM: begin
          // count down, back to idle at end
          if (cnt_q == 16'h0001) begin
            state_q <= NVMCA_IDLE;
          end
          cnt_q <= cnt_q - 16'h0001;
        end
        default: begin
          state_q <= NVMCA_IDLE;
          cnt_q <= 16'h0000;
        end
      endcase
    end
  end

  // active while any operation runs
  assign otp_active = state_q != NVMCA_IDLE;

  // ----------------------------------------
  // power-up refresh and origin flag
  // ----------------------------------------
  // one automatic refresh after reset loads the defaults
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      boot_q <= 1'b1;
      host_op_q <= 1'b0;
    end else if (ce) begin
      if (start_ref) begin
        boot_q <= 1'b0;
        host_op_q <= !boot_q;
      end
    end
  end

  // ----------------------------------------
  // fuse macro drive
  // ----------------------------------------
  // program word is the mapped fields with lock forced on
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fuse_read <= 1'b0;
      fuse_prog <= 1'b0;
      fuse_bias_high <= 1'b0;
      fuse_bias_low <= 1'b0;
      fuse_wdata <= '0;
    end else if (ce) begin
      if (start_ref) begin
        fuse_read <= 1'b1;
        fuse_bias_high <= bias_high && !boot_q;
        fuse_bias_low <= bias_low && !boot_q;
      end else if (start_prog) begin
        fuse_prog <= 1'b1;
        fuse_wdata <= {1'b1, cfg_fields};
      end else if (finish) begin
        fuse_read <= 1'b0;
        fuse_prog <= 1'b0;
        fuse_bias_high <= 1'b0;
        fuse_bias_low <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // store image, lock and defaults
  // ----------------------------------------
  // image captured at end of each refresh; lock also set by programming
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      image_q <= '0;
      lock_q <= 1'b0;
      cfg_default_valid <= 1'b0;
    end else if (ce) begin
      if (finish && state_q == NVMCA_REFRESH) begin
        image_q <= fuse_rdata;
        lock_q <= lock_q || fuse_rdata[POS_LOCK];
        cfg_default_valid <= 1'b1;
      end else if (finish && state_q == NVMCA_PROGRAM) begin
        lock_q <= 1'b1;
      end
    end
  end

  // stored fields drive the chip defaults
  assign cfg_default = nvmca_cfg_s'(image_q[POS_LOCK-1:0]);

  // ----------------------------------------
  // readback slice register
  // ----------------------------------------
  // updates only at the end of a host refresh
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data_q <= DATA_RESET;
    end else if (ce) begin
      if (finish && state_q == NVMCA_REFRESH && host_op_q) begin
        data_q <= slice_of(fuse_rdata, slice_addr);
      end
    end
  end

  // ----------------------------------------
  // programming failure flag
  // ----------------------------------------
  // set wins over the clearing read
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fail_q <= 1'b0;
    end else if (ce) begin
      if (state_q == NVMCA_PROGRAM && boost_uv) begin
        fail_q <= 1'b1;
      end else if (status_rd) begin
        fail_q <= 1'b0;
      end
    end
  end
  // flag drives the status output directly
  assign prog_fail = fail_q;

  // ----------------------------------------
  // trim register
  // ----------------------------------------
  // factory nibble loaded later; parity odd over nibble
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      trim_q <= TRIM_RESET;
    end else if (ce) begin
      if (trim_load) begin
        trim_q <= {1'b0, ~^spare_trim_nibble, 4'h0, spare_trim_nibble};
      end
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  // one-cycle read latency, unmapped reads zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else if (ce) begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_TRIM: rdata_q <= trim_q;
          ADDR_DATA: rdata_q <= data_q;
          ADDR_REV: rdata_q <= {1'b0, REV_FIXED_HI[3:0], REV_FULL_MASK, 1'b0, REV_METAL};
          default: rdata_q <= '0;
        endcase
      end
    end
  end
  // read port outputs straight from their flops
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // host refresh request taken while idle
  sequence s_ref_req;
    ce && state_q == NVMCA_IDLE && !boot_q && op_wr && op_code == NVMCA_OP_REFRESH;
  endsequence
  // read strobe and busy both held for four cycles
  sequence s_ref_run;
    (fuse_read && otp_active) [*4];
  endsequence
  // frozen clock enable with an operation in flight
  sequence s_frozen_run;
    !ce && otp_active;
  endsequence

  // a host refresh keeps strobe and busy up
  a_refresh_active: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_ref_req |=> s_ref_run) else $error("refresh did not hold active");
  a_nop_codes: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && state_q == NVMCA_IDLE && !boot_q && op_wr && (op_code == NVMCA_OP_NOP || op_code == NVMCA_OP_NOP3)
    |=> state_q == NVMCA_IDLE) else $error("no-op code started an operation");
  a_lock_blocks: assert property (@(posedge ref_clk) disable iff (!resetn)
    lock_q && $rose(fuse_prog) |-> 1'b0) else $error("program started while locked");
  a_lock_written: assert property (@(posedge ref_clk) disable iff (!resetn)
    fuse_prog |-> fuse_wdata[POS_LOCK]) else $error("lock bit missing from program word");
  a_prog_fields: assert property (@(posedge ref_clk) disable iff (!resetn)
    start_prog |=> fuse_prog && fuse_wdata[38:0] == $past(cfg_fields)) else $error("program word wrong");
  a_slice_map: assert property (@(posedge ref_clk) disable iff (!resetn)
    finish && state_q == NVMCA_REFRESH && host_op_q
    |=> data_q == slice_of($past(fuse_rdata), $past(slice_addr))) else $error("slice mismatch");
  // undervoltage while programming raises the flag
  a_fail_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && state_q == NVMCA_PROGRAM && boost_uv |=> prog_fail) else $error("fail flag not set");
  a_busy_ignore: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && otp_active && cnt_q > 16'h0001 && op_wr |=> otp_active && $stable(state_q))
    else $error("operation write taken while busy");
  a_trim_parity: assert property (@(posedge ref_clk) disable iff (!resetn)
    ce && trim_load |=> ^trim_q[8:0] == 1'b1 && trim_q[9] == 1'b0) else $error("trim parity not odd");
  a_prog_locks: assert property (@(posedge ref_clk) disable iff (!resetn)
    finish && state_q == NVMCA_PROGRAM |=> lock_q ##1 !start_prog) else $error("lock not set after program");
  // busy and countdown hold while the clock enable is low
  a_ce_freeze: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_frozen_run |=> otp_active && $stable(cnt_q) && $stable(state_q)) else $error("state moved while frozen");
  // the power-up refresh leaves the readback slice alone
  a_boot_keeps_data: assert property (@(posedge ref_clk) disable iff (!resetn)
    finish && state_q == NVMCA_REFRESH && !host_op_q |=> $stable(data_q))
    else $error("power-up refresh changed data");
endmodule

// File: test/nvmca_fuse_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// behavioural fuse array on the far side
// ----------------------------------------
module nvmca_fuse_model (
  input wire logic ref_clk,
  input wire logic fuse_read,
  input wire logic fuse_prog,
  input wire logic [39:0] fuse_wdata,
  output logic [39:0] fuse_rdata
);
  // forty one-time cells, preset by the bench before reset ends
  logic [39:0] fuse_cells_q;
  // programming can only blow cells, never clear them
  always @(posedge ref_clk) begin
    if (fuse_prog === 1'b1) begin
      fuse_cells_q <= fuse_cells_q | fuse_wdata;
    end
  end
  // outside a read the bus is not valid, so show the inverse content
  assign fuse_rdata = (fuse_read === 1'b1) ? fuse_cells_q : ~fuse_cells_q;
endmodule

// File: test/nvm_config_access_test.sv
`timescale 1ns/10ps
module nvm_config_access_test;
  import nvmca_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  localparam int PCYC = 20; // short program time for simulation
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic reg_rd = 1'b0, op_wr = 1'b0, bias_high = 1'b0, bias_low = 1'b0;
  logic status_rd = 1'b0, trim_load = 1'b0, boost_uv = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [1:0] op_code = 2'h0, slice_addr = 2'h0;
  logic [3:0] spare_trim_nibble = 4'h0;
  nvmca_cfg_s cfg_fields = '0, cfg_default;
  logic [9:0] reg_rdata, v;
  logic reg_rvalid, otp_active, prog_fail, cfg_default_valid, fuse_read, fuse_prog;
  logic fuse_bias_high, fuse_bias_low;
  logic [39:0] fuse_wdata, fuse_rdata, exp_mem, wd_seen;
  int seed, n_mismatch = 0, checks_done = 0, prog_cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  nvmca_ctrl #(.PROG_CYC(PCYC)) i_nvmca_ctrl (.ref_clk(ref_clk), .resetn(resetn), .ce(ce), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .op_wr(op_wr), .op_code(op_code),
    .slice_addr(slice_addr), .bias_high(bias_high), .bias_low(bias_low), .cfg_fields(cfg_fields),
    .status_rd(status_rd), .otp_active(otp_active), .prog_fail(prog_fail), .cfg_default(cfg_default),
    .cfg_default_valid(cfg_default_valid), .trim_load(trim_load), .spare_trim_nibble(spare_trim_nibble),
    .boost_uv(boost_uv), .fuse_read(fuse_read), .fuse_prog(fuse_prog), .fuse_bias_high(fuse_bias_high),
    .fuse_bias_low(fuse_bias_low), .fuse_wdata(fuse_wdata), .fuse_rdata(fuse_rdata));
  nvmca_fuse_model i_nvmca_fuse_model (.ref_clk(ref_clk), .fuse_read(fuse_read), .fuse_prog(fuse_prog),
    .fuse_wdata(fuse_wdata), .fuse_rdata(fuse_rdata));
  // count program cycles and keep the word offered to the fuses
  always @(posedge ref_clk) begin
    if (fuse_prog === 1'b1) begin
      prog_cycles <= prog_cycles + 1;
      wd_seen <= fuse_wdata;
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input string what, input logic [39:0] exp, input logic [39:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one register read, data taken with the valid pulse
  task rd(input logic [4:0] a, output logic [9:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("read valid", 40'h1, {39'h0, reg_rvalid});
    d = reg_rdata;
  endtask
  // issue an operation, optionally poke a write, undervoltage or a clock-enable pause, count busy cycles
  task op(input logic [1:0] c, input int exp_n, input int poke);
    int n;
    n = 0;
    while (otp_active !== 1'b0 && n < 30000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    n = 0;
    @(posedge ref_clk);
    op_wr <= 1'b1;
    op_code <= c;
    @(posedge ref_clk);
    op_wr <= 1'b0;
    #1;
    if (c == 2'h1) chk("read bias", {37'h1, bias_high, bias_low}, {37'h0, fuse_read, fuse_bias_high, fuse_bias_low});
    while (otp_active === 1'b1 && n < 30000) begin
      @(posedge ref_clk);
      op_wr <= (poke == 1 && n == 5);
      op_code <= (poke == 1) ? 2'h2 : c;
      boost_uv <= (poke == 2 && n == 5);
      ce <= !(poke == 3 && n >= 5 && n < 8);
      #1;
      n++;
    end
    chk("busy cycles", 40'(exp_n), 40'(n));
  endtask
  // expected trim word: parity bit makes the count of ones odd
  function automatic logic [9:0] trim_exp(input logic [3:0] nib);
    int ones;
    ones = 0;
    for (int k = 0; k < 4; k++) ones += nib[k];
    return {1'b0, ones % 2 == 0, 4'h0, nib};
  endfunction
  task results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h8ba7b6d9;
    exp_mem = {1'b0, 7'($random(seed)), 32'($random(seed))};
    i_nvmca_fuse_model.fuse_cells_q = exp_mem;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(ADDR_DATA, v);
    chk("data reset", 40'(DATA_RESET), 40'(v));
    rd(ADDR_TRIM, v);
    chk("trim reset", 40'(TRIM_RESET), 40'(v));
    rd(ADDR_REV, v);
    chk("revision", 40'({1'b0, 1'b1, 3'h0, REV_FULL_MASK, 1'b0, REV_METAL}), 40'(v));
    rd(5'h05, v);
    chk("unmapped", 40'h0, 40'(v));
    // trim nibble loads with odd parity
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      trim_load <= 1'b1;
      spare_trim_nibble <= (i == 0) ? 4'h0 : 4'($random(seed));
      @(posedge ref_clk);
      trim_load <= 1'b0;
      rd(ADDR_TRIM, v);
      chk("trim parity", 40'(trim_exp(spare_trim_nibble)), 40'(v));
    end
    // refresh every slice with random margin settings
    for (int s = 0; s < 4; s++) begin
      slice_addr <= 2'(s);
      bias_high <= 1'($random(seed));
      bias_low <= 1'($random(seed));
      op(2'h1, 100, 0);
      rd(ADDR_DATA, v);
      chk("slice", 40'(exp_mem[s*10 +: 10]), 40'(v));
    end
    op(2'h0, 0, 0);
    op(2'h3, 0, 0);
    // a program write during a refresh is dropped
    op(2'h1, 100, 1);
    chk("no program", 40'h0, 40'(prog_cycles));
    // program with undervoltage in mid-run
    cfg_fields <= nvmca_cfg_s'(39'({$random(seed), $random(seed)}));
    op(2'h2, PCYC, 2);
    chk("program word", {1'b1, cfg_fields}, wd_seen);
    chk("program span", 40'(PCYC), 40'(prog_cycles));
    exp_mem = exp_mem | {1'b1, cfg_fields};
    chk("fail flag", 40'h1, 40'(prog_fail));
    @(posedge ref_clk);
    status_rd <= 1'b1;
    @(posedge ref_clk);
    status_rd <= 1'b0;
    #1;
    chk("fail cleared", 40'h0, 40'(prog_fail));
    slice_addr <= 2'h3;
    // clock enable dropped for three cycles stretches the refresh
    op(2'h1, 103, 3);
    rd(ADDR_DATA, v);
    chk("lock slice", 40'(exp_mem[39:30]), 40'(v));
    chk("default cfg", {exp_mem[38:0], 1'b1}, {cfg_default, cfg_default_valid});
    // a second program is refused once locked
    op(2'h2, 0, 0);
    chk("no reprogram", 40'(PCYC), 40'(prog_cycles));
    results();
  end
endmodule
